// ---- rld_pkg.sv ----
// Purpose: Constants and types for the read latency sequencer
// Assumes: 24-bit addresses, serial clock mode 0, single data rate only
// Notes:   Opcode values are named here and used by name only
package rld_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned CMD_BITS  = 8;
  localparam int unsigned ADDR_BITS = 24;
  localparam int unsigned LANES     = 4;
  localparam int unsigned CNT_BITS  = 6;
  localparam int unsigned SYNC_W    = 6;
  localparam logic [5:0]  SYNC_IDLE = 6'h10;

  // ****************************************
  // Command opcodes
  // ****************************************
  localparam logic [7:0] OP_READ      = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_QUAD_IO   = 8'hEB;
  localparam logic [7:0] read_any_register_cmd    = 8'h65;
  localparam logic [7:0] security_region_read_cmd = 8'h4B;
  localparam logic [7:0] parameter_table_read_cmd = 8'h5A;
  localparam logic [7:0] OP_UNIQUE_ID = 8'h4C;
  localparam logic [7:0] OP_PD_EXIT   = 8'hAB;

  // ****************************************
  // Cycle counts
  // ****************************************
  localparam logic [5:0] CMD_EDGES_SINGLE  = 6'h07;
  localparam logic [5:0] CMD_EDGES_QUAD    = 6'h01;
  localparam logic [5:0] ADDR_EDGES_SINGLE = 6'h17;
  localparam logic [5:0] ADDR_EDGES_QUAD   = 6'h05;
  localparam logic [5:0] QIO_MODE_EDGES    = 6'h01;
  localparam logic [5:0] UNIQUE_ID_DUMMY   = 6'h20;
  localparam logic [5:0] PD_EXIT_DUMMY     = 6'h18;
  localparam logic [5:0] LAT_ZERO_DUMMY    = 6'h08;
  localparam logic [2:0] SINGLE_LAST_BIT   = 3'h7;
  localparam logic [2:0] QUAD_LAST_NIBBLE  = 3'h1;
  localparam logic [3:0] OE_SINGLE         = 4'h2;
  localparam logic [3:0] OE_QUAD           = 4'hF;

  // ****************************************
  // Host side clock limits in MHz
  // ****************************************
  localparam int unsigned MAX_SDR_MHZ = 133;
  localparam int unsigned MAX_DDR_MHZ = 66;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CMD    = 3'b001,
    ST_ADDR   = 3'b010,
    ST_MODE   = 3'b011,
    ST_DUMMY  = 3'b100,
    ST_DATA   = 3'b101,
    ST_IGNORE = 3'b110
  } rld_state_e;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] sync;
  } rld_sync_s;

  typedef struct packed {
    rld_state_e            state;
    logic [CMD_BITS-1:0]   cmd;
    logic [ADDR_BITS-1:0]  sh;
    logic [ADDR_BITS-1:0]  addr;
    logic [CNT_BITS-1:0]   cnt;
    logic [7:0]            obuf;
    logic [2:0]            bcnt;
    logic                  wide;
    logic                  load;
    logic                  sck_prev;
    logic [LANES-1:0]      io_out;
    logic [LANES-1:0]      io_oe;
    logic                  byte_req;
  } rld_state_s;

endpackage

// ---- rld_link_if.sv ----
// Purpose: Synchronised link pins between synchroniser and sequencer
// Assumes: All signals on ref_clk
// Notes:   src drives, dst reads
`timescale 1ns/100ps
interface rld_link_if;
  logic       sck;
  logic       cs_n;
  logic [3:0] io;
  modport src (output sck, output cs_n, output io);
  modport dst (input sck, input cs_n, input io);
endinterface

// ---- rld_sync.sv ----
// Purpose: Two-stage synchroniser for the link pins
// Assumes: Pins are asynchronous to ref_clk
// Notes:   Only the second stage is visible outside
`timescale 1ns/100ps
module rld_sync (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic       sck_pin,
  input  wire logic       cs_n_pin,
  input  wire logic [3:0] io_in,
  rld_link_if.src         link
);

  rld_pkg::rld_sync_s q;
  rld_pkg::rld_sync_s d;

  always_comb begin
    d      = q;
    d.meta = {sck_pin, cs_n_pin, io_in};
    d.sync = q.meta;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{meta: rld_pkg::SYNC_IDLE, sync: rld_pkg::SYNC_IDLE};
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign link.sck  = q.sync[5];
  assign link.cs_n = q.sync[4];
  assign link.io   = q.sync[3:0];

endmodule // rld_sync

// ---- rld_read_latency.sv ----
// Purpose: Device side read sequencer with dummy cycle latency
// Assumes: Serial clock mode 0, input sampled on rising, output on falling
// Notes:   Read data comes from rd_data for the byte at addr_out
`timescale 1ns/100ps
module rld_read_latency (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic       sck_pin,
  input  wire logic       cs_n_pin,
  input  wire logic [3:0] io_in,
  input  wire logic       four_lane_command_mode,
  input  wire logic [3:0] latency_code_field,
  input  wire logic [7:0] rd_data,
  output logic      [3:0] io_out,
  output logic      [3:0] io_oe,
  output logic            byte_req,
  output logic     [23:0] addr_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  rld_link_if link ();

  rld_sync u_sync (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .sck_pin  (sck_pin),
    .cs_n_pin (cs_n_pin),
    .io_in    (io_in),
    .link     (link)
  );

  // ****************************************
  // Sequencer state
  // ****************************************
  rld_pkg::rld_state_s q;
  rld_pkg::rld_state_s d;
  logic                sck_rise;
  logic                sck_fall;
  logic [23:0]         sh_next;
  logic [5:0]          var_dummy;
  logic [7:0]          new_cmd;

  assign sck_rise = link.sck & ~q.sck_prev;
  assign sck_fall = ~link.sck & q.sck_prev;
  assign sh_next  = q.wide ? {q.sh[19:0], link.io} : {q.sh[22:0], link.io[0]};
  assign new_cmd  = sh_next[7:0];

  assign var_dummy = (latency_code_field == 4'h0) ? rld_pkg::LAT_ZERO_DUMMY
                                                  : {2'b00, latency_code_field};

  always_comb begin
    d          = q;
    d.sck_prev = link.sck;
    d.byte_req = 1'b0;
    // Byte arrives the cycle after the request
    if (q.byte_req) begin
      d.obuf = rd_data;
    end
    if (q.load) begin
      d.load     = 1'b0;
      d.byte_req = 1'b1;
    end
    if (link.cs_n) begin
      d.state  = rld_pkg::ST_IDLE;
      d.io_oe  = 4'h0;
      d.io_out = 4'h0;
      d.load   = 1'b0;
    end else begin
      case (q.state)
        rld_pkg::ST_IDLE: begin
          d.state = rld_pkg::ST_CMD;
          d.wide  = four_lane_command_mode;
          d.addr  = 24'h00_0000;
          d.cnt   = four_lane_command_mode ? rld_pkg::CMD_EDGES_QUAD
                                           : rld_pkg::CMD_EDGES_SINGLE;
        end
        rld_pkg::ST_CMD: begin
          if (sck_rise) begin
            d.sh  = sh_next;
            d.cnt = q.cnt - 6'h01;
            if (q.cnt == 6'h00) begin
              d.cmd = new_cmd;
              case (new_cmd)
                rld_pkg::OP_READ, rld_pkg::OP_FAST_READ, rld_pkg::OP_QUAD_IO,
                rld_pkg::read_any_register_cmd, rld_pkg::security_region_read_cmd,
                rld_pkg::parameter_table_read_cmd: begin
                  d.state = rld_pkg::ST_ADDR;
                  d.wide  = four_lane_command_mode | (new_cmd == rld_pkg::OP_QUAD_IO);
                  d.cnt   = d.wide ? rld_pkg::ADDR_EDGES_QUAD : rld_pkg::ADDR_EDGES_SINGLE;
                end
                rld_pkg::OP_UNIQUE_ID: begin
                  d.state = rld_pkg::ST_DUMMY;
                  d.cnt   = rld_pkg::UNIQUE_ID_DUMMY - 6'h01;
                end
                rld_pkg::OP_PD_EXIT: begin
                  d.state = rld_pkg::ST_DUMMY;
                  d.cnt   = rld_pkg::PD_EXIT_DUMMY - 6'h01;
                end
                default: begin
                  d.state = rld_pkg::ST_IGNORE;
                end
              endcase
            end
          end
        end
        rld_pkg::ST_ADDR: begin
          if (sck_rise) begin
            d.sh  = sh_next;
            d.cnt = q.cnt - 6'h01;
            if (q.cnt == 6'h00) begin
              d.addr = sh_next;
              if (q.cmd == rld_pkg::OP_QUAD_IO) begin
                d.state = rld_pkg::ST_MODE;
                d.cnt   = rld_pkg::QIO_MODE_EDGES;
              end else if (q.cmd == rld_pkg::OP_READ) begin
                d.state = rld_pkg::ST_DATA;
                d.load  = 1'b1;
                d.bcnt  = 3'h0;
              end else begin
                d.state = rld_pkg::ST_DUMMY;
                d.cnt   = var_dummy - 6'h01;
              end
            end
          end
        end
        rld_pkg::ST_MODE: begin
          if (sck_rise) begin
            d.cnt = q.cnt - 6'h01;
            if (q.cnt == 6'h00) begin
              d.state = rld_pkg::ST_DUMMY;
              d.cnt   = var_dummy - 6'h01;
            end
          end
        end
        rld_pkg::ST_DUMMY: begin
          if (sck_rise) begin
            d.cnt = q.cnt - 6'h01;
            if (q.cnt == 6'h00) begin
              d.state = rld_pkg::ST_DATA;
              d.load  = 1'b1;
              d.bcnt  = 3'h0;
            end
          end
        end
        rld_pkg::ST_DATA: begin
          // drive data from first falling edge
          if (sck_fall && !q.load && !q.byte_req) begin
            d.bcnt = q.bcnt + 3'h1;
            if (q.wide) begin
              d.io_out = q.obuf[7:4];
              d.io_oe  = rld_pkg::OE_QUAD;
              d.obuf   = {q.obuf[3:0], 4'h0};
              if (q.bcnt == rld_pkg::QUAD_LAST_NIBBLE) begin
                d.bcnt = 3'h0;
                d.addr = q.addr + 24'h00_0001;
                d.load = 1'b1;
              end
            end else begin
              d.io_out = {2'b00, q.obuf[7], 1'b0};
              d.io_oe  = rld_pkg::OE_SINGLE;
              d.obuf   = {q.obuf[6:0], 1'b0};
              if (q.bcnt == rld_pkg::SINGLE_LAST_BIT) begin
                d.addr = q.addr + 24'h00_0001;
                d.load = 1'b1;
              end
            end
          end
        end
        rld_pkg::ST_IGNORE: begin
          d.io_oe = 4'h0;
        end
        default: begin
          d.state = rld_pkg::ST_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign io_out   = q.io_out;
  assign io_oe    = q.io_oe;
  assign byte_req = q.byte_req;
  assign addr_out = q.addr;

  // ****************************************
  // Assertions
  // ****************************************
  // outputs off in address, mode and dummy phases
  a_oe_off_wait: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (q.state inside {rld_pkg::ST_MODE, rld_pkg::ST_DUMMY, rld_pkg::ST_ADDR})
      |-> (q.io_oe == 4'h0))
    else $error("Data lanes driven outside data phase");

  a_data_drive_start: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && q.state == rld_pkg::ST_DATA && !q.load && !q.byte_req && sck_fall
      && !link.cs_n)
      |=> (q.io_oe != 4'h0))
    else $error("Data not driven on falling edge");

  // plain read goes straight to data
  a_plain_read_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && q.state == rld_pkg::ST_ADDR && d.state != rld_pkg::ST_ADDR
      && q.cmd == rld_pkg::OP_READ && !link.cs_n)
      |=> (q.state == rld_pkg::ST_DATA && q.load))
    else $error("Plain read inserted dummy cycles");

  a_qio_mode_two: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && q.state == rld_pkg::ST_ADDR && d.state != rld_pkg::ST_ADDR
      && q.cmd == rld_pkg::OP_QUAD_IO && !link.cs_n)
      |=> (q.state == rld_pkg::ST_MODE && q.cnt == 6'h01))
    else $error("Quad I/O read lacks two mode cycles");

  a_mode_not_counted: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && q.state == rld_pkg::ST_MODE && d.state == rld_pkg::ST_DUMMY)
      |-> (d.cnt == ((latency_code_field == 4'h0) ? 6'h07
                                                  : {2'b00, latency_code_field} - 6'h01)))
    else $error("Mode cycles counted into latency");

  a_unique_id_fixed: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && q.state == rld_pkg::ST_CMD && d.state == rld_pkg::ST_DUMMY
      && d.cmd == rld_pkg::OP_UNIQUE_ID)
      |=> (q.cnt == 6'h1F))
    else $error("Unique ID read not 32 dummies");

  a_pd_exit_fixed: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && q.state == rld_pkg::ST_CMD && d.state == rld_pkg::ST_DUMMY
      && d.cmd == rld_pkg::OP_PD_EXIT)
      |=> (q.cnt == 6'h17))
    else $error("Power-down exit not 24 dummies");

  a_zero_code_eight: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && q.state == rld_pkg::ST_ADDR && d.state == rld_pkg::ST_DUMMY
      && latency_code_field == 4'h0)
      |=> (q.cnt == 6'h07))
    else $error("Latency code zero not eight dummies");

  a_code_count: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && q.state == rld_pkg::ST_ADDR && d.state == rld_pkg::ST_DUMMY
      && latency_code_field != 4'h0)
      |=> (q.cnt == {2'b00, $past(latency_code_field)} - 6'h01))
    else $error("Dummy count differs from latency code");

  a_dummy_to_data: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && q.state == rld_pkg::ST_DUMMY && q.cnt == 6'h00 && sck_rise && !link.cs_n)
      |=> (q.state == rld_pkg::ST_DATA) ##1 (!$past(clk_en) || q.byte_req))
    else $error("Data phase did not follow last dummy");

endmodule // rld_read_latency

// ---- rld_host_model.sv ----
// Purpose: Host controller model for the serial read link
// Assumes: Mode 0, clock low between frames, 125 ns link period at the default half_ns
// Notes:   Released lanes show the inverse of their last value
`timescale 1ns/100ps
module rld_host_model (
  output logic            sck_pin,
  output logic            cs_n_pin,
  output logic      [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  real half_ns = 62.5;
  int  oe_idle_bad;
  int  oe_data_bad;

  initial begin
    sck_pin  = 1'b0;
    cs_n_pin = 1'b1;
    io_in    = 4'h5;
  end

  // ****************************************
  // Link beats
  // ****************************************
  // Clock far below limits
  task automatic beat(input logic [3:0] v, output logic [3:0] s, output logic [3:0] oe);
    io_in = v;
    #(half_ns) sck_pin = 1'b1;
    s  = io_out;
    oe = io_oe;
    #(half_ns) sck_pin = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] op, input bit cq, input bit wq, input int na,
                      input logic [23:0] a, input int nm, input int nd, input int nb,
                      input bit quiet, output logic [7:0] rx [$]);
    logic [31:0] sh;
    logic [3:0]  s;
    logic [3:0]  oe;
    logic [7:0]  b;
    int          step;
    rx          = {};
    oe_idle_bad = 0;
    oe_data_bad = 0;
    sh          = {op, a};
    // Keep pin changes off the ref_clk edges
    #1;
    cs_n_pin    = 1'b0;
    for (int i = 0; i < 8 + na; i += step) begin
      step = ((i < 8) ? cq : wq) ? 4 : 1;
      beat((step == 4) ? sh[31-i -: 4] : {~io_in[3:1], sh[31-i]}, s, oe);
      oe_idle_bad += int'(oe !== 4'h0);
    end
    repeat (nm + nd) begin
      beat(~io_in, s, oe);
      oe_idle_bad += int'(oe !== 4'h0);
    end
    repeat (nb) begin
      for (int k = 0; k < 8; k += (wq ? 4 : 1)) begin
        beat(~io_in, s, oe);
        b = wq ? {b[3:0], s} : {b[6:0], s[1]};
        if (quiet)
          oe_idle_bad += int'(oe !== 4'h0);
        else
          oe_data_bad += int'(oe !== (wq ? 4'hF : 4'h2));
      end
      rx.push_back(b);
    end
    cs_n_pin = 1'b1;
    io_in    = ~io_in;
    #(4 * half_ns);
  endtask
endmodule // rld_host_model

// ---- rld_read_latency_tb.sv ----
// Purpose: Self-checking bench for the read latency sequencer
// Assumes: Host model runs the link, bench serves read bytes
// Notes:   Fixed seed keeps the random run repeatable
`timescale 1ns/100ps
module rld_read_latency_tb;
  localparam int TIMEOUT_CYC = 80000;
  logic        ref_clk;
  logic        arst_n;
  logic        four_lane_command_mode;
  logic [3:0]  latency_code_field;
  logic [7:0]  rd_data;
  logic        sck_pin;
  logic        cs_n_pin;
  logic [3:0]  io_in;
  logic [3:0]  io_out;
  logic [3:0]  io_oe;
  logic        byte_req;
  logic [23:0] addr_out;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;
  int          req_cnt = 0;
  logic        clk_en;
  bit          stall_on = 1'b0;
  integer      seed = 32'h8032_5ff9;
  logic [7:0]  var_ops [3];

  rld_read_latency rld_read_latency_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .sck_pin(sck_pin),
    .cs_n_pin(cs_n_pin), .io_in(io_in), .four_lane_command_mode(four_lane_command_mode),
    .latency_code_field(latency_code_field), .rd_data(rd_data), .io_out(io_out),
    .io_oe(io_oe), .byte_req(byte_req), .addr_out(addr_out)
  );
  rld_host_model rld_host_model_inst (
    .sck_pin(sck_pin), .cs_n_pin(cs_n_pin), .io_in(io_in), .io_out(io_out), .io_oe(io_oe)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Expectations
  // ****************************************
  function automatic logic [7:0] exp_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'hA5;
  endfunction

  function automatic int exp_dummy(input logic [7:0] op, input logic [3:0] code);
    if (op == rld_pkg::OP_READ) return 0;
    if (op == rld_pkg::OP_UNIQUE_ID) return 32;
    if (op == rld_pkg::OP_PD_EXIT) return 24;
    return (code == 4'h0) ? 8 : int'(code);
  endfunction

  always @(posedge ref_clk) begin
    rd_data <= exp_byte(addr_out);
    clk_en <= !(stall_on && ($random(seed) % 4 == 0));
    if (byte_req && clk_en) req_cnt <= req_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == TIMEOUT_CYC) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_int(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic run(input logic [7:0] op, input bit q, input logic [3:0] code,
                     input bit quiet);
    logic [7:0]  rx [$];
    logic [23:0] a;
    bit          no_addr;
    bit          w;
    int          n0;
    no_addr = (op == rld_pkg::OP_UNIQUE_ID) || (op == rld_pkg::OP_PD_EXIT);
    w       = q || (op == rld_pkg::OP_QUAD_IO);
    a       = no_addr ? 24'h00_0000 : 24'($random(seed));
    @(posedge ref_clk);
    four_lane_command_mode <= q;
    latency_code_field     <= code;
    repeat (3) @(posedge ref_clk);
    n0 = req_cnt;
    rld_host_model_inst.xfer(op, q, w, no_addr ? 0 : 24, a,
                             (op == rld_pkg::OP_QUAD_IO) ? 2 : 0,
                             quiet ? 8 : exp_dummy(op, code), 3, quiet, rx);
    cmp_int("idle lanes", 0, rld_host_model_inst.oe_idle_bad);
    cmp_int("byte requests", quiet ? 0 : 4, req_cnt - n0);
    cmp_int("end address", quiet ? 24'h00_0000 : a + 24'h00_0003, addr_out);
    if (!quiet) begin
      cmp_int("data enables", 0, rld_host_model_inst.oe_data_bad);
      for (int i = 0; i < 3; i++)
        cmp_byte("read byte", exp_byte(a + 24'(i)), rx[i]);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    arst_n                 = 1'b0;
    four_lane_command_mode = 1'b0;
    latency_code_field     = 4'h0;
    rd_data                = 8'h00;
    clk_en                 = 1'b1;
    var_ops = '{rld_pkg::read_any_register_cmd, rld_pkg::security_region_read_cmd,
                rld_pkg::parameter_table_read_cmd};
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    run(rld_pkg::OP_READ, 1'b0, 4'($random(seed)), 1'b0);
    for (int c = 0; c < 16; c++) run(rld_pkg::OP_FAST_READ, 1'b0, 4'(c), 1'b0);
    for (int c = 0; c < 6; c++)
      run(var_ops[c % 3], c >= 3, (c == 0) ? 4'h0 : (c == 5) ? 4'hF : 4'($random(seed)),
          1'b0);
    run(rld_pkg::OP_QUAD_IO, 1'b0, 4'h0, 1'b0);
    run(rld_pkg::OP_QUAD_IO, 1'b0, 4'($random(seed)), 1'b0);
    run(rld_pkg::OP_QUAD_IO, 1'b1, 4'hF, 1'b0);
    run(rld_pkg::OP_UNIQUE_ID, 1'b0, 4'($random(seed)), 1'b0);
    run(rld_pkg::OP_PD_EXIT, 1'b0, 4'($random(seed)), 1'b0);
    run(8'h00, 1'b0, 4'h0, 1'b1);
    rld_host_model_inst.half_ns = 150.0;
    stall_on = 1'b1;
    run(rld_pkg::OP_FAST_READ, 1'b0, 4'h3, 1'b0);
    complete_run();
  end
endmodule // rld_read_latency_tb
